// ---- logic/intc_pkg.sv ----
// constants, register map and state encoding for the interrupt flag acceptance unit
// assumes one 250 MHz clock and a word-indexed register port
// Operation
// - maskable requests blocked while enable flag is 0, allowed while 1
// - every acknowledge clears the enable flag
// - stack select flag 0 picks interrupt stack pointer, 1 picks user stack pointer
// - stack select cleared on hardware acknowledge and software interrupts 0 to 31
// - processor priority level is three bits, levels 0 to 7
// - maskable request accepted only if its priority exceeds the processor level
// - reserved flag bit is written as 0, reads carry no meaning
// - fixed interrupt vectors come from table at 0FFDCh to 0FFFFh
// - saved context goes to internal RAM starting at 00400h
// - sixty-nine vectors, seven selectable priority levels
// - sixteen external sources: eight pin interrupts and eight key inputs
package intc_pkg;
  // ----------------------------------------
  // register map (word index)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] A_FLAG = 4'h0;
  localparam logic [3:0] A_INT_SP = 4'h1;
  localparam logic [3:0] A_USR_SP = 4'h2;
  localparam logic [3:0] A_VTB = 4'h3;
  localparam logic [3:0] A_PRIO_LO = 4'h4;
  localparam logic [3:0] A_PRIO_HI = 4'h5;
  localparam logic [3:0] A_STAT = 4'h6;
  localparam logic [3:0] A_CLR = 4'h7;
  localparam logic [3:0] A_EN = 4'h8;
  // ----------------------------------------
  // flag layout
  // ----------------------------------------
  localparam int FLAG_W = 16;
  localparam int BIT_I = 6;
  localparam int BIT_U = 7;
  localparam int LEVEL_LSB = 12;
  localparam int LEVEL_W = 3;
  localparam int BIT_RSV = 15;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  // ----------------------------------------
  // memory map
  // ----------------------------------------
  localparam int AW = 20;
  localparam logic [19:0] RAM_BASE = 20'h00400;
  localparam logic [19:0] INT_SP_RST = 20'h01C00;
  localparam logic [19:0] USR_SP_RST = 20'h01C00;
  localparam logic [19:0] VTB_RST = 20'h0FD00;
  localparam logic [19:0] FIX_BASE = 20'h0FFDC;
  localparam logic [19:0] FIX_TOP = 20'h0FFFF;
  localparam logic [19:0] PUSH_STEP = 20'h00002;
  // ----------------------------------------
  // sources and vectors
  // ----------------------------------------
  localparam int SRC_N = 16;
  localparam int FIX_N = 9;
  localparam int VEC_N = 69;
  localparam int VAR_N = VEC_N - FIX_N;
  localparam int NUM_W = 7;
  localparam int SWI_W = 6;
  localparam logic [5:0] SWI_U_MAX = 6'h1F;
  localparam logic [6:0] EXT_VEC0 = 7'h20;
  localparam int PRIO_FLD = 4;
  // ----------------------------------------
  // status events
  // ----------------------------------------
  localparam int EV_W = 4;
  localparam int ST_EXT = 0;
  localparam int ST_FIX = 1;
  localparam int ST_SWI = 2;
  localparam int ST_OVF = 3;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PUSH = 2'b01,
    S_VEC = 2'b11
  } state_t;
endpackage : intc_pkg

// ---- logic/intc_accept.sv ----
// interrupt acceptance unit: flags, priority compare, stack push and vector fetch address
// assumes requests and strobes synchronous to i_clock; core raises i_boundary between instructions
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module intc_accept
  import intc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [SRC_N-1:0] i_ext_req,
  input wire logic [FIX_N-1:0] i_fix_req,
  input wire logic i_swi_valid,
  input wire logic [SWI_W-1:0] i_swi_num,
  input wire logic i_boundary,
  output logic o_push_valid,
  output logic [AW-1:0] o_push_addr,
  output logic [FLAG_W-1:0] o_push_data,
  output logic o_vec_valid,
  output logic [AW-1:0] o_vec_addr,
  output logic [NUM_W-1:0] o_vec_num,
  output logic o_flag_i,
  output logic o_flag_u,
  output logic [LEVEL_W-1:0] o_processor_priority_level,
  output logic [AW-1:0] o_sp,
  output logic o_irq
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [LEVEL_W-1:0] prio_of(
    input logic [2*DATA_W-1:0] p,
    input int k
  );
    prio_of = p[k*PRIO_FLD +: LEVEL_W];
  endfunction : prio_of

  function automatic logic [AW-1:0] vec_of(
    input logic [AW-1:0] base,
    input logic [NUM_W-1:0] n
  );
    vec_of = base + {11'h000, n, 2'h0};
  endfunction : vec_of

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t state_reg;
  logic [FLAG_W-1:0] flag_reg;
  logic [AW-1:0] int_sp_reg;
  logic [AW-1:0] usr_sp_reg;
  logic [AW-1:0] vtb_reg;
  logic [DATA_W-1:0] prio_lo_reg;
  logic [DATA_W-1:0] prio_hi_reg;
  logic [EV_W-1:0] sts_reg;
  logic [EV_W-1:0] en_reg;
  logic [AW-1:0] vec_addr_reg;
  logic [NUM_W-1:0] vec_num_reg;

  logic [2*DATA_W-1:0] prio_all;
  logic [LEVEL_W-1:0] processor_priority_level;
  logic fix_hit;
  logic [3:0] fix_idx;
  logic ext_found;
  logic ext_hit;
  logic [3:0] ext_idx;
  logic [LEVEL_W-1:0] ext_pr;
  logic swi_ok;
  logic use_fix;
  logic use_swi;
  logic use_ext;
  logic take;
  logic clr_u;
  logic [FLAG_W-1:0] flag_next;
  logic push_u;
  logic [AW-1:0] sp_sel;
  logic [AW-1:0] sp_next;
  logic [NUM_W-1:0] num_next;
  logic [AW-1:0] addr_next;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] sts_next;
  logic wr_flag;

  assign prio_all = {prio_hi_reg, prio_lo_reg};
  assign processor_priority_level = flag_reg[LEVEL_LSB +: LEVEL_W];
  assign wr_flag = i_wr && (i_addr == A_FLAG);

  // ----------------------------------------
  // request selection
  // ----------------------------------------
  always_comb begin
    fix_hit = 1'b0;
    fix_idx = 4'h0;
    for (int k = FIX_N - 1; k >= 0; k--) begin
      if (i_fix_req[k]) begin
        fix_hit = 1'b1;
        fix_idx = 4'(k);
      end
    end
  end

  // a source priority of 0 can never beat any level, so 0 disables it
  always_comb begin
    ext_found = 1'b0;
    ext_idx = 4'h0;
    ext_pr = processor_priority_level;
    for (int k = 0; k < SRC_N; k++) begin
      if (i_ext_req[k] && (prio_of(prio_all, k) > ext_pr)) begin
        ext_found = 1'b1;
        ext_idx = 4'(k);
        ext_pr = prio_of(prio_all, k);
      end
    end
  end

  assign ext_hit = ext_found && flag_reg[BIT_I];
  assign swi_ok = i_swi_valid && (32'(i_swi_num) < VAR_N);
  // fixed requests are non-maskable and win; the instruction beats maskable requests
  assign use_fix = fix_hit;
  assign use_swi = !fix_hit && swi_ok;
  assign use_ext = !fix_hit && !swi_ok && ext_hit;
  assign take = (state_reg == S_IDLE) && i_boundary && (use_fix || use_swi || use_ext);
  assign clr_u = use_fix || use_ext || (use_swi && (i_swi_num <= SWI_U_MAX));

  // ----------------------------------------
  // flag update on acknowledge
  // ----------------------------------------
  always_comb begin
    flag_next = flag_reg;
    flag_next[BIT_I] = 1'b0;
    if (clr_u) begin
      flag_next[BIT_U] = 1'b0;
    end
    if (use_ext) begin
      flag_next[LEVEL_LSB +: LEVEL_W] = ext_pr;
    end
  end

  assign push_u = flag_next[BIT_U];
  assign sp_sel = push_u ? usr_sp_reg : int_sp_reg;
  assign sp_next = sp_sel - PUSH_STEP;

  always_comb begin
    if (use_fix) begin
      num_next = 7'(VAR_N) + {3'h0, fix_idx};
      addr_next = vec_of(FIX_BASE, {3'h0, fix_idx});
    end else if (use_swi) begin
      num_next = {1'b0, i_swi_num};
      addr_next = vec_of(vtb_reg, {1'b0, i_swi_num});
    end else begin
      num_next = EXT_VEC0 + {3'h0, ext_idx};
      addr_next = vec_of(vtb_reg, EXT_VEC0 + {3'h0, ext_idx});
    end
  end

  // ----------------------------------------
  // sequencer: accept, push old flags, present vector
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            state_reg <= S_PUSH;
          end
        end
        S_PUSH: begin
          state_reg <= S_VEC;
        end
        S_VEC: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // acknowledge outranks a software write landing in the same cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_reg <= FLAG_RST;
    end else if (take) begin
      flag_reg <= flag_next;
    end else if (wr_flag) begin
      flag_reg <= {1'b0, i_wdata[FLAG_W-2:0]};
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      int_sp_reg <= INT_SP_RST;
      usr_sp_reg <= USR_SP_RST;
    end else begin
      if (take && !push_u) begin
        int_sp_reg <= sp_next;
      end else if (i_wr && (i_addr == A_INT_SP)) begin
        int_sp_reg <= i_wdata[AW-1:0];
      end
      if (take && push_u) begin
        usr_sp_reg <= sp_next;
      end else if (i_wr && (i_addr == A_USR_SP)) begin
        usr_sp_reg <= i_wdata[AW-1:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_push_valid <= 1'b0;
      o_push_addr <= '0;
      o_push_data <= FLAG_RST;
      vec_addr_reg <= '0;
      vec_num_reg <= '0;
    end else begin
      o_push_valid <= take;
      if (take) begin
        o_push_addr <= sp_next;
        o_push_data <= flag_reg;
        vec_addr_reg <= addr_next;
        vec_num_reg <= num_next;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_vec_valid <= 1'b0;
      o_vec_addr <= '0;
      o_vec_num <= '0;
    end else begin
      o_vec_valid <= (state_reg == S_PUSH);
      if (state_reg == S_PUSH) begin
        o_vec_addr <= vec_addr_reg;
        o_vec_num <= vec_num_reg;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag_i <= 1'b0;
      o_flag_u <= 1'b0;
      o_processor_priority_level <= '0;
      o_sp <= INT_SP_RST;
    end else begin
      o_flag_i <= flag_reg[BIT_I];
      o_flag_u <= flag_reg[BIT_U];
      o_processor_priority_level <= processor_priority_level;
      o_sp <= flag_reg[BIT_U] ? usr_sp_reg : int_sp_reg;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      vtb_reg <= VTB_RST;
      prio_lo_reg <= '0;
      prio_hi_reg <= '0;
      en_reg <= '0;
    end else if (i_wr) begin
      case (i_addr)
        A_VTB: vtb_reg <= i_wdata[AW-1:0];
        A_PRIO_LO: prio_lo_reg <= i_wdata;
        A_PRIO_HI: prio_hi_reg <= i_wdata;
        A_EN: en_reg <= i_wdata[EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // event status and interrupt line
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[ST_EXT] = take && use_ext;
    ev[ST_FIX] = take && use_fix;
    ev[ST_SWI] = take && use_swi;
    // a push below the RAM floor still happens; software learns of it here
    ev[ST_OVF] = take && (sp_next < RAM_BASE);
    sts_next = sts_reg;
    if (i_wr && (i_addr == A_CLR)) begin
      sts_next = sts_reg & ~i_wdata[EV_W-1:0];
    end
    sts_next = sts_next | ev;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sts_reg <= '0;
      o_irq <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      o_irq <= |(sts_reg & en_reg);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        A_FLAG: o_rdata <= {17'h00000, flag_reg[FLAG_W-2:0]};
        A_INT_SP: o_rdata <= {12'h000, int_sp_reg};
        A_USR_SP: o_rdata <= {12'h000, usr_sp_reg};
        A_VTB: o_rdata <= {12'h000, vtb_reg};
        A_PRIO_LO: o_rdata <= prio_lo_reg;
        A_PRIO_HI: o_rdata <= prio_hi_reg;
        A_STAT: o_rdata <= {28'h0000000, sts_reg};
        A_EN: o_rdata <= {28'h0000000, en_reg};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  chk_mask_block: assert property (take && use_ext |-> flag_reg[BIT_I])
    else $error("maskable request taken with enable flag clear");
  chk_enable_clear: assert property (take |=> !flag_reg[BIT_I] ##1 !o_flag_i)
    else $error("enable flag not cleared on acknowledge");
  chk_sp_select: assert property (##1 o_sp == $past(flag_reg[BIT_U] ? usr_sp_reg : int_sp_reg))
    else $error("active stack pointer does not follow select flag");
  chk_select_clear: assert property (take && clr_u |=> !flag_reg[BIT_U])
    else $error("stack select flag not cleared");
  chk_level_load: assert property (take && use_ext |=> processor_priority_level == $past(ext_pr))
    else $error("processor level not raised to accepted level");
  chk_prio_pass: assert property (take && use_ext |-> ext_pr > processor_priority_level)
    else $error("request accepted without exceeding processor level");
  chk_rsv_read: assert property (i_rd && i_addr == A_FLAG |=> !o_rdata[BIT_RSV])
    else $error("reserved flag bit read as one");
  chk_fixed_table: assert property (o_vec_valid && o_vec_num >= 7'(VAR_N)
      |-> o_vec_addr >= FIX_BASE && o_vec_addr <= FIX_TOP)
    else $error("fixed vector outside fixed table");
  chk_push_ram: assert property (o_push_valid |-> o_push_addr >= RAM_BASE || sts_reg[ST_OVF])
    else $error("push below RAM without overflow status");
  chk_vec_count: assert property (o_vec_valid |-> o_vec_num < 7'(VEC_N))
    else $error("vector number out of range");
  chk_ext_number: assert property (take && use_ext |-> ##2 o_vec_num == $past(num_next, 2))
    else $error("external source vector number lost");
  chk_push_order: assert property (take |=> o_push_valid && o_push_data == $past(flag_reg)
      ##1 o_vec_valid)
    else $error("old flags not pushed before vector");

  cov_fixed: cover property (take && use_fix ##2 o_vec_valid);
  cov_swi_high: cover property (take && use_swi && i_swi_num > SWI_U_MAX);
  cov_nested: cover property (take && use_ext ##3 take && use_ext);

endmodule : intc_accept

// ---- dv/irq_sources.sv ----
// far-side model: peripherals and pins that hold interrupt requests
// assumes the unit's push pulse marks the moment a source is served
`timescale 1ns/1ns
module irq_sources
  import intc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [SRC_N-1:0] i_raise_ext,
  input wire logic [FIX_N-1:0] i_raise_fix,
  input wire logic i_ack,
  output logic [SRC_N-1:0] o_ext_req,
  output logic [FIX_N-1:0] o_fix_req
);
  // requests are levels held until served; the bench raises one source at a time except 16'h0600 in s_prio,
  // where dropping all on the acknowledge also drops the losing source; it avoids a fixed-source retake
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_req <= '0;
      o_fix_req <= '0;
    end else if (i_ack) begin
      o_ext_req <= '0;
      o_fix_req <= '0;
    end else begin
      o_ext_req <= o_ext_req | i_raise_ext;
      o_fix_req <= o_fix_req | i_raise_fix;
    end
  end
endmodule : irq_sources

// ---- dv/tb.sv ----
// self-checking bench for the interrupt acceptance unit
// assumes the unit's own assertions run alongside; request sources come from irq_sources
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module tb;
  import intc_pkg::*;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_swi_valid = 1'b0, i_boundary = 1'b0;
  logic [ADDR_W-1:0] i_addr = 4'h0;
  logic [DATA_W-1:0] i_wdata = 32'h0, o_rdata;
  logic [SWI_W-1:0] i_swi_num = 6'h00;
  logic [SRC_N-1:0] i_ext_req, raise_ext = 16'h0000;
  logic [FIX_N-1:0] i_fix_req, raise_fix = 9'h000;
  logic o_push_valid, o_vec_valid, o_flag_i, o_flag_u, o_irq;
  logic [AW-1:0] o_push_addr, o_vec_addr, o_sp, int_e = INT_SP_RST, usr_e = USR_SP_RST;
  logic [FLAG_W-1:0] o_push_data;
  logic [NUM_W-1:0] o_vec_num;
  logic [LEVEL_W-1:0] o_processor_priority_level;
  int fail_count = 0, cmp_count = 0;
  always #2 i_clock = ~i_clock;
  intc_accept u_intc_accept (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_req(i_ext_req), .i_fix_req(i_fix_req),
    .i_swi_valid(i_swi_valid), .i_swi_num(i_swi_num), .i_boundary(i_boundary),
    .o_push_valid(o_push_valid), .o_push_addr(o_push_addr), .o_push_data(o_push_data),
    .o_vec_valid(o_vec_valid), .o_vec_addr(o_vec_addr), .o_vec_num(o_vec_num), .o_flag_i(o_flag_i),
    .o_flag_u(o_flag_u), .o_processor_priority_level(o_processor_priority_level), .o_sp(o_sp), .o_irq(o_irq));
  irq_sources u_irq_sources (.i_clock(i_clock), .i_nrst(i_nrst), .i_raise_ext(raise_ext),
    .i_raise_fix(raise_fix), .i_ack(o_push_valid), .o_ext_req(i_ext_req), .o_fix_req(i_fix_req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] fl(input logic i, input logic u, input logic [2:0] p);
    return {16'h0000, 1'b0, p, 4'h0, u, i, 6'h00};
  endfunction : fl
  function automatic logic [19:0] va(input logic [6:0] n);
    return VTB_RST + (20'(n) << 2);
  endfunction : va
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clock) i_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clock) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clock) i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask : rd_chk
  task automatic raise(input logic [15:0] e, input logic [8:0] f);
    @(posedge i_clock) {raise_ext, raise_fix} <= {e, f};
    @(posedge i_clock) {raise_ext, raise_fix} <= 25'h0;
  endtask : raise
  task automatic swi(input logic [5:0] n);
    @(posedge i_clock) {i_swi_valid, i_swi_num} <= {1'b1, n};
    @(posedge i_clock) i_swi_valid <= 1'b0;
  endtask : swi
  task automatic no_ack();
    repeat (6) begin
      @(posedge i_clock);
      #1;
      `CHK(o_push_valid, 1'b0)
    end
  endtask : no_ack
  task automatic ack(input logic [6:0] n, input logic [19:0] v, input logic on_u, input logic [31:0] old,
    input logic [2:0] p, input logic u);
    int k = 0;
    #1;
    while (o_push_valid !== 1'b1 && k < 10) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    if (on_u) usr_e -= PUSH_STEP;
    else int_e -= PUSH_STEP;
    `CHK(o_push_valid, 1'b1)
    `CHK(o_push_data, old[15:0])
    `CHK(o_push_addr, (on_u ? usr_e : int_e))
    @(posedge i_clock);
    #1;
    `CHK(o_vec_valid, 1'b1)
    `CHK(o_vec_num, n)
    `CHK(o_vec_addr, v)
    `CHK(o_flag_i, 1'b0)
    `CHK(o_flag_u, u)
    `CHK(o_processor_priority_level, p)
    @(posedge i_clock);
    #1;
    `CHK(o_vec_valid, 1'b0)
  endtask : ack
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    #1;
    `CHK(o_sp, INT_SP_RST)
    rd_chk(A_FLAG, 32'h0);
    rd_chk(A_INT_SP, 32'(INT_SP_RST));
    rd_chk(A_VTB, 32'(VTB_RST));
    rd_chk(4'hF, 32'h0);
  endtask : s_reset
  task automatic s_mask();
    wr(A_EN, 32'h1);
    wr(A_PRIO_LO, 32'h5000);
    raise(16'h0008, 9'h000);
    no_ack();
    wr(A_FLAG, fl(1, 0, 2));
    ack(7'd35, va(7'd35), 0, fl(1, 0, 2), 3'd5, 0);
    `CHK(o_irq, 1'b1)
    rd_chk(A_STAT, 32'h1);
    wr(A_EN, 32'h0);
    @(posedge i_clock);
    #1;
    `CHK(o_irq, 1'b0)
    wr(A_EN, 32'h1);
    wr(A_CLR, 32'h1);
    @(posedge i_clock);
    #1;
    `CHK(o_irq, 1'b0)
  endtask : s_mask
  task automatic s_prio();
    wr(A_FLAG, fl(1, 0, 5));
    wr(A_PRIO_HI, 32'h50);
    raise(16'h0200, 9'h000);
    no_ack();
    wr(A_PRIO_HI, 32'h60);
    ack(7'd41, va(7'd41), 0, fl(1, 0, 5), 3'd6, 0);
    wr(A_FLAG, fl(1, 0, 0));
    wr(A_PRIO_HI, 32'h760);
    raise(16'h0600, 9'h000);
    ack(7'd42, va(7'd42), 0, fl(1, 0, 0), 3'd7, 0);
  endtask : s_prio
  task automatic s_ext_all();
    for (int k = 0; k < 16; k++) begin
      wr(A_FLAG, fl(1, 0, 0));
      wr((k < 8) ? A_PRIO_LO : A_PRIO_HI, 32'h1 << (4 * (k % 8)));
      raise(16'h1 << k, 9'h000);
      ack(7'(32 + k), va(7'(32 + k)), 0, fl(1, 0, 0), 3'd1, 0);
    end
  endtask : s_ext_all
  task automatic s_stack();
    wr(A_FLAG, fl(1, 1, 7));
    rd_chk(A_FLAG, fl(1, 1, 7));
    rd_chk(A_USR_SP, 32'(usr_e));
    @(posedge i_clock);
    #1;
    `CHK(o_sp, usr_e)
    swi(6'd31);
    ack(7'd31, va(7'd31), 0, fl(1, 1, 7), 3'd7, 0);
    `CHK(o_sp, int_e)
    wr(A_FLAG, fl(1, 1, 7));
    swi(6'd32);
    ack(7'd32, va(7'd32), 1, fl(1, 1, 7), 3'd7, 1);
    swi(6'd60);
    no_ack();
  endtask : s_stack
  task automatic s_fixed();
    wr(A_FLAG, fl(0, 0, 0));
    wr(A_CLR, 32'hF);
    for (int k = 0; k < FIX_N; k++) begin
      raise(16'h0000, 9'h1 << k);
      ack(7'(60 + k), FIX_BASE + 20'(4 * k), 0, 32'h0, 3'd0, 0);
    end
    wr(A_INT_SP, 32'h401);
    int_e = 20'h00401;
    raise(16'h0000, 9'h001);
    ack(7'd60, FIX_BASE, 0, 32'h0, 3'd0, 0);
    rd_chk(A_STAT, 32'hA);
  endtask : s_fixed
  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    i_boundary <= 1'b1;
    s_reset();
    s_mask();
    s_prio();
    s_ext_all();
    s_stack();
    s_fixed();
    summarize();
  end
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : tb
